// [design/wcc_pkg.sv]
// shared constants and types of the watchdog control block
package wcc_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL_ONE  = 6'h00;
  localparam logic [5:0] IDX_COUNTER_HIGH = 6'h02;
  localparam logic [5:0] IDX_COUNTER_LOW  = 6'h03;
  localparam logic [5:0] IDX_TIMEOUT_HIGH = 6'h04;
  localparam logic [5:0] IDX_TIMEOUT_LOW  = 6'h05;
  localparam logic [5:0] IDX_EVENT_STATUS = 6'h10;
  localparam logic [5:0] IDX_EVENT_MASK   = 6'h11;

  // control one field positions
  localparam int BIT_ENABLE      = 7;
  localparam int BIT_IRQ_ENABLE  = 6;
  localparam int BIT_UPDATE      = 5;
  localparam int BIT_CHECK_HI    = 4;
  localparam int BIT_CHECK_LO    = 3;
  localparam int BIT_DEBUG       = 2;
  localparam int BIT_WAIT        = 1;
  localparam int BIT_STOP        = 0;

  // event status / mask bit positions
  localparam int EVT_TIMEOUT     = 0;
  localparam int EVT_ILLEGAL     = 1;

  // reset values
  localparam logic [7:0]  CONTROL_ONE_RESET = 8'h80;
  localparam logic [15:0] TIMEOUT_RESET     = 16'h0004;
  localparam logic [1:0]  CHECK_MODE_RESET  = 2'h0;

  // counter check modes
  localparam logic [1:0] CHECK_OFF      = 2'h0;
  localparam logic [1:0] CHECK_USER     = 2'h1;
  localparam logic [1:0] CHECK_LOW_BYTE = 2'h2;
  localparam logic [1:0] CHECK_HI_BYTE  = 2'h3;

  // counter command words
  localparam logic [15:0] UNLOCK_WORD_ONE  = 16'h20C5;
  localparam logic [15:0] UNLOCK_WORD_TWO  = 16'h28D9;
  localparam logic [15:0] REFRESH_WORD_ONE = 16'h02A6;
  localparam logic [15:0] REFRESH_WORD_TWO = 16'h80B4;

  // timing counts in bus clocks
  localparam logic [7:0] RESET_DELAY_CLKS = 8'h80;
  localparam logic [7:0] UNLOCK_WIN_CLKS  = 8'h80;
  localparam logic [4:0] SEQ_GAP_CLKS     = 5'h10;

  typedef enum logic [1:0] {
    WCC_SEQ_NONE    = 2'b00,
    WCC_SEQ_UNLOCK  = 2'b01,
    WCC_SEQ_REFRESH = 2'b10
  } wcc_seq_e;

  typedef enum logic [1:0] {
    WCC_RUN      = 2'b00,
    WCC_IRQ_WAIT = 2'b01,
    WCC_DELAY    = 2'b10,
    WCC_RESET    = 2'b11
  } wcc_rst_e;

endpackage : wcc_pkg

// [design/wcc_watchdog.sv]
// watchdog core with control register one, counter, timeout and ahb-lite slave
//
// Notes on behaviour
// - counter counts only while enable bit set
// - interrupt option raises irq before reset if the event's mask bit is set
// - timeout and illegal write both trigger
// - reset follows vector fetch by 128 clocks
// - no interrupt option: immediate reset, no irq
// - update bit: writes only in unlock window
// - no update bit: later change forces reset
// - configuration fields accept one write only, except inside the unlock window
// - check mode cleared by power-on reset only
// - check modes 00/01 compare full words
// - low byte mode compares low bytes
// - mode 11 compares high bytes only
// - debug mode stops counter unless enabled
// - wait mode stops counter unless enabled
// - stop mode stops counter unless enabled
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

module wcc_watchdog (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        count_tick,
  input  wire logic        debug_mode,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        vector_fetch,
  output logic             irq,
  output logic             wdog_reset
);

  typedef struct packed {
    logic                enable;
    logic                irq_enable;
    logic                update;
    logic                debug_mode_enable;
    logic                wait_enable;
    logic                stop_enable;
    logic                cfg_done;
    logic [15:0]         timeout;
    logic [15:0]         counter;
    logic                unlock_open;
    logic [7:0]          unlock_left;
    wcc_pkg::wcc_seq_e   seq;
    logic [4:0]          seq_left;
    wcc_pkg::wcc_rst_e   rst_state;
    logic [7:0]          delay_left;
    logic [1:0]          status;
    logic [1:0]          mask;
    logic                irq;
    logic                wdog_reset;
    logic                ap_valid;
    logic                ap_write;
    logic [5:0]          ap_idx;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
  } wcc_state_s;

  wcc_state_s  st;
  wcc_state_s  next_st;
  logic [1:0]  counter_check_mode;
  logic [1:0]  next_counter_check_mode;

  logic        cfg_write_ok;
  logic        running;
  logic        match;
  logic        timeout_evt;
  logic        illegal_evt;
  logic        take;
  logic [15:0] cmd_word;
  logic [1:0]  evt_vec;
  logic [1:0]  clear_vec;
  logic [7:0]  control_one_rd;
  logic        addr_mapped;
  // decoded counter command words
  logic        unlock_one;
  logic        unlock_two;
  logic        refresh_one;
  logic        refresh_two;
  // chip states that freeze the counter
  logic        debug_hold;
  logic        wait_hold;
  logic        stop_hold;

  always_comb begin
    next_st = st;
    next_counter_check_mode = counter_check_mode;
    illegal_evt = 1'b0;
    clear_vec = 2'b00;
    cmd_word = hwdata[15:0];
    addr_mapped = (haddr[31:8] == 24'h00_0000);

    // counter command words, acted on in the write data phase
    unlock_one  = (cmd_word == wcc_pkg::UNLOCK_WORD_ONE);
    unlock_two  = (cmd_word == wcc_pkg::UNLOCK_WORD_TWO);
    refresh_one = (cmd_word == wcc_pkg::REFRESH_WORD_ONE);
    refresh_two = (cmd_word == wcc_pkg::REFRESH_WORD_TWO);

    // reconfiguration: first write after reset, or inside unlock window
    cfg_write_ok = !st.cfg_done || (st.update && st.unlock_open);

    // counter gating by chip low-power and debug states
    debug_hold = debug_mode && !st.debug_mode_enable;
    wait_hold  = wait_mode && !st.wait_enable;
    stop_hold  = stop_mode && !st.stop_enable;
    running    = st.enable && !debug_hold && !wait_hold && !stop_hold
                 && (st.rst_state == wcc_pkg::WCC_RUN);

    case (counter_check_mode)
      wcc_pkg::CHECK_LOW_BYTE: match = (st.counter[7:0] == st.timeout[7:0]);
      wcc_pkg::CHECK_HI_BYTE:  match = (st.counter[15:8] == st.timeout[15:8]);
      default:                 match = (st.counter == st.timeout);
    endcase
    timeout_evt = running && match;

    // the counter freezes at the match so the event cannot slip past
    if (running && count_tick && !match) begin
      next_st.counter = st.counter + 16'h0001;
    end

    // unlock window countdown
    if (st.unlock_open) begin
      if (st.unlock_left == 8'h00) begin
        next_st.unlock_open = 1'b0;
      end else begin
        next_st.unlock_left = st.unlock_left - 8'h01;
      end
    end

    // two-word sequence gap countdown
    if (st.seq != wcc_pkg::WCC_SEQ_NONE) begin
      if (st.seq_left == 5'h00) begin
        next_st.seq = wcc_pkg::WCC_SEQ_NONE;
      end else begin
        next_st.seq_left = st.seq_left - 5'h01;
      end
    end

    // write data phase
    // a refused configuration write is not stored; it counts as illegal
    if (st.ap_valid && st.ap_write) begin
      if (st.ap_idx == wcc_pkg::IDX_CONTROL_ONE) begin
        if (cfg_write_ok) begin
          next_st.enable            = hwdata[wcc_pkg::BIT_ENABLE];
          next_st.irq_enable        = hwdata[wcc_pkg::BIT_IRQ_ENABLE];
          next_st.update            = hwdata[wcc_pkg::BIT_UPDATE];
          next_st.debug_mode_enable = hwdata[wcc_pkg::BIT_DEBUG];
          next_st.wait_enable       = hwdata[wcc_pkg::BIT_WAIT];
          next_st.stop_enable       = hwdata[wcc_pkg::BIT_STOP];
          next_counter_check_mode   = hwdata[wcc_pkg::BIT_CHECK_HI:wcc_pkg::BIT_CHECK_LO];
          next_st.cfg_done          = 1'b1;
        end else begin
          illegal_evt = 1'b1;
        end
      end else if (st.ap_idx == wcc_pkg::IDX_TIMEOUT_HIGH) begin
        if (cfg_write_ok) begin
          next_st.timeout[15:8] = hwdata[7:0];
          next_st.cfg_done      = 1'b1;
        end else begin
          illegal_evt = 1'b1;
        end
      end else if (st.ap_idx == wcc_pkg::IDX_TIMEOUT_LOW) begin
        if (cfg_write_ok) begin
          next_st.timeout[7:0] = hwdata[7:0];
          next_st.cfg_done     = 1'b1;
        end else begin
          illegal_evt = 1'b1;
        end
      end else if (st.ap_idx == wcc_pkg::IDX_COUNTER_HIGH) begin
        if (st.seq == wcc_pkg::WCC_SEQ_UNLOCK && unlock_two) begin
          next_st.seq         = wcc_pkg::WCC_SEQ_NONE;
          next_st.unlock_open = 1'b1;
          next_st.unlock_left = wcc_pkg::UNLOCK_WIN_CLKS - 8'h01;
        end else if (st.seq == wcc_pkg::WCC_SEQ_REFRESH && refresh_two) begin
          next_st.seq     = wcc_pkg::WCC_SEQ_NONE;
          next_st.counter = 16'h0000;
        end else if (unlock_one && st.update) begin
          next_st.seq      = wcc_pkg::WCC_SEQ_UNLOCK;
          next_st.seq_left = wcc_pkg::SEQ_GAP_CLKS - 5'h01;
        end else if (refresh_one) begin
          next_st.seq      = wcc_pkg::WCC_SEQ_REFRESH;
          next_st.seq_left = wcc_pkg::SEQ_GAP_CLKS - 5'h01;
        end else begin
          illegal_evt = 1'b1;
        end
      end else if (st.ap_idx == wcc_pkg::IDX_COUNTER_LOW) begin
        illegal_evt = 1'b1;
      end else if (st.ap_idx == wcc_pkg::IDX_EVENT_STATUS) begin
        clear_vec = hwdata[1:0];
      end else if (st.ap_idx == wcc_pkg::IDX_EVENT_MASK) begin
        next_st.mask = hwdata[1:0];
      end
    end

    // sticky events; a set in the clearing cycle wins
    evt_vec = 2'b00;
    if (st.rst_state == wcc_pkg::WCC_RUN && st.irq_enable) begin
      evt_vec[wcc_pkg::EVT_TIMEOUT] = timeout_evt;
      evt_vec[wcc_pkg::EVT_ILLEGAL] = illegal_evt;
    end
    next_st.status = (st.status & ~clear_vec) | evt_vec;
    next_st.irq = |(next_st.status & next_st.mask) && next_st.irq_enable;

    // reset sequencing
    // with the interrupt option the reset waits for the vector fetch alone; the
    // status mask gates only irq and does not hold the sequence here
    case (st.rst_state)
      wcc_pkg::WCC_RUN: begin
        if (timeout_evt || illegal_evt) begin
          if (st.irq_enable) begin
            next_st.rst_state = wcc_pkg::WCC_IRQ_WAIT;
          end else begin
            next_st.rst_state  = wcc_pkg::WCC_RESET;
            next_st.wdog_reset = 1'b1;
          end
        end
      end
      wcc_pkg::WCC_IRQ_WAIT: begin
        if (vector_fetch) begin
          next_st.rst_state  = wcc_pkg::WCC_DELAY;
          next_st.delay_left = wcc_pkg::RESET_DELAY_CLKS - 8'h01;
        end
      end
      wcc_pkg::WCC_DELAY: begin
        if (st.delay_left == 8'h00) begin
          next_st.rst_state  = wcc_pkg::WCC_RESET;
          next_st.wdog_reset = 1'b1;
        end else begin
          next_st.delay_left = st.delay_left - 8'h01;
        end
      end
      wcc_pkg::WCC_RESET: begin
        // held until the system reset takes the block down
        next_st.wdog_reset = 1'b1;
      end
      default: begin
        next_st.rst_state = wcc_pkg::WCC_RUN;
      end
    endcase

    // address phase capture and read data
    take = hsel && htrans[1] && hready;
    next_st.ap_valid = take;
    next_st.ap_write = hwrite;
    next_st.ap_idx   = haddr[7:2];
    control_one_rd = 8'h00;
    control_one_rd[wcc_pkg::BIT_ENABLE]     = st.enable;
    control_one_rd[wcc_pkg::BIT_IRQ_ENABLE] = st.irq_enable;
    control_one_rd[wcc_pkg::BIT_UPDATE]     = st.update;
    control_one_rd[wcc_pkg::BIT_CHECK_HI:wcc_pkg::BIT_CHECK_LO] = counter_check_mode;
    control_one_rd[wcc_pkg::BIT_DEBUG]      = st.debug_mode_enable;
    control_one_rd[wcc_pkg::BIT_WAIT]       = st.wait_enable;
    control_one_rd[wcc_pkg::BIT_STOP]       = st.stop_enable;
    next_st.hrdata = 32'h0000_0000;
    if (take && !hwrite && addr_mapped) begin
      if (haddr[7:2] == wcc_pkg::IDX_CONTROL_ONE) begin
        next_st.hrdata = {24'h00_0000, control_one_rd};
      end else if (haddr[7:2] == wcc_pkg::IDX_COUNTER_HIGH) begin
        next_st.hrdata = {24'h00_0000, st.counter[15:8]};
      end else if (haddr[7:2] == wcc_pkg::IDX_COUNTER_LOW) begin
        next_st.hrdata = {24'h00_0000, st.counter[7:0]};
      end else if (haddr[7:2] == wcc_pkg::IDX_TIMEOUT_HIGH) begin
        next_st.hrdata = {24'h00_0000, st.timeout[15:8]};
      end else if (haddr[7:2] == wcc_pkg::IDX_TIMEOUT_LOW) begin
        next_st.hrdata = {24'h00_0000, st.timeout[7:0]};
      end else if (haddr[7:2] == wcc_pkg::IDX_EVENT_STATUS) begin
        next_st.hrdata = {30'h0000_0000, st.status};
      end else if (haddr[7:2] == wcc_pkg::IDX_EVENT_MASK) begin
        next_st.hrdata = {30'h0000_0000, st.mask};
      end
    end
    // transfers outside the block's window are dropped without an event
    if (!addr_mapped) begin
      next_st.ap_valid = 1'b0;
    end
    next_st.hreadyout = 1'b1;
    // okay is the only response this slave gives
    next_st.hresp = 1'b0;
  end

  // one register stage holds all state except the check mode; every output comes straight from it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.enable            <= wcc_pkg::CONTROL_ONE_RESET[wcc_pkg::BIT_ENABLE];
      st.irq_enable        <= wcc_pkg::CONTROL_ONE_RESET[wcc_pkg::BIT_IRQ_ENABLE];
      st.update            <= wcc_pkg::CONTROL_ONE_RESET[wcc_pkg::BIT_UPDATE];
      st.debug_mode_enable <= wcc_pkg::CONTROL_ONE_RESET[wcc_pkg::BIT_DEBUG];
      st.wait_enable       <= wcc_pkg::CONTROL_ONE_RESET[wcc_pkg::BIT_WAIT];
      st.stop_enable       <= wcc_pkg::CONTROL_ONE_RESET[wcc_pkg::BIT_STOP];
      st.cfg_done          <= 1'b0;
      st.timeout           <= wcc_pkg::TIMEOUT_RESET;
      st.counter           <= 16'h0000;
      st.unlock_open       <= 1'b0;
      st.unlock_left       <= 8'h00;
      st.seq               <= wcc_pkg::WCC_SEQ_NONE;
      st.seq_left          <= 5'h00;
      st.rst_state         <= wcc_pkg::WCC_RUN;
      st.delay_left        <= 8'h00;
      st.status            <= 2'b00;
      st.mask              <= 2'b00;
      st.irq               <= 1'b0;
      st.wdog_reset        <= 1'b0;
      st.ap_valid          <= 1'b0;
      st.ap_write          <= 1'b0;
      st.ap_idx            <= 6'h00;
      st.hrdata            <= 32'h0000_0000;
      st.hreadyout         <= 1'b1;
      st.hresp             <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // check mode survives every reset except power-on
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      counter_check_mode <= wcc_pkg::CHECK_MODE_RESET;
    end else begin
      counter_check_mode <= next_counter_check_mode;
    end
  end

  assign hrdata     = st.hrdata;
  assign hreadyout  = st.hreadyout;
  assign hresp      = st.hresp;
  assign irq        = st.irq;
  assign wdog_reset = st.wdog_reset;

endmodule // wcc_watchdog

// [dv/test_watchdog_control_config.sv]
// self-checking testbench of the watchdog control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module test_watchdog_control_config;
  localparam logic [31:0] A_CTRL = {24'h0, wcc_pkg::IDX_CONTROL_ONE, 2'b00};
  localparam logic [31:0] A_CMD  = {24'h0, wcc_pkg::IDX_COUNTER_HIGH, 2'b00};
  localparam logic [31:0] A_CNT  = {24'h0, wcc_pkg::IDX_COUNTER_LOW, 2'b00};
  localparam logic [31:0] A_TOH  = {24'h0, wcc_pkg::IDX_TIMEOUT_HIGH, 2'b00};
  localparam logic [31:0] A_TOL  = {24'h0, wcc_pkg::IDX_TIMEOUT_LOW, 2'b00};
  localparam logic [31:0] A_STAT = {24'h0, wcc_pkg::IDX_EVENT_STATUS, 2'b00};
  localparam logic [31:0] A_MASK = {24'h0, wcc_pkg::IDX_EVENT_MASK, 2'b00};
  logic        hclk, hresetn, por_n, hsel, hwrite, hreadyout, hresp, irq, wdog_reset;
  logic        count_tick, debug_mode, wait_mode, stop_mode, vector_fetch;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  logic  hready;
  int          bad_count, num_checks;

  assign hready = hreadyout;

  wcc_watchdog uut (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .count_tick, .debug_mode, .wait_mode,
    .stop_mode, .vector_fetch, .irq, .wdog_reset);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one single transfer; read data lands in rd_val
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_val = hrdata;
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd_val)
  endtask

  task automatic tick(input int n);
    @(posedge hclk);
    count_tick <= 1'b1;
    repeat (n) @(posedge hclk);
    count_tick <= 1'b0;
  endtask

  task automatic rst(input logic por);
    @(posedge hclk);
    hresetn <= 1'b0;
    por_n <= !por;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
  endtask

  task automatic test_reset();
    rdchk("control one", A_CTRL, 32'h80);
    rdchk("timeout low", A_TOL, 32'h04);
    rdchk("unmapped", 32'h0000_0100, 32'h0);
    $display("test reset done");
  endtask

  // counts three ticks under a given configuration and chip mode
  task automatic gate(input logic [7:0] ctl, input logic [2:0] md, input logic [7:0] e);
    rst(1'b1);
    bus(1'b1, A_CTRL, {24'h0, ctl});
    {debug_mode, wait_mode, stop_mode} <= md;
    tick(3);
    {debug_mode, wait_mode, stop_mode} <= 3'h0;
    rdchk("counter low", A_CNT, {24'h0, e});
  endtask

  task automatic test_gates();
    gate(8'h00, 3'h0, 8'h00);
    gate(8'h80, 3'h0, 8'h03);
    for (int i = 0; i < 3; i++) begin
      gate(8'h80, 3'(1 << i), 8'h00);
      gate(8'h80 | 8'(1 << i), 3'(1 << i), 8'h03);
    end
    $display("test gates done");
  endtask

  // timeout 0x0104: ticks to a match per check mode
  task automatic test_modes();
    int n[4] = '{260, 260, 4, 256};
    for (int m = 0; m < 4; m++) begin
      rst(1'b1);
      // counter held off until the timeout is set: high-byte mode matches 0x00 at once
      bus(1'b1, A_CTRL, 32'h20 | 32'(m << 3));
      bus(1'b1, A_CMD, 32'h20C5);
      bus(1'b1, A_CMD, 32'h28D9);
      bus(1'b1, A_TOH, 32'h01);
      bus(1'b1, A_CTRL, 32'hA0 | 32'(m << 3));
      tick(n[m] - 1);
      repeat (2) @(posedge hclk);
      `CHK("early reset", 1'b0, wdog_reset)
      tick(1);
      repeat (2) @(posedge hclk);
      `CHK("reset", 1'b1, wdog_reset)
      `CHK("irq off", 1'b0, irq)
      rst(1'b0);
      rdchk("mode kept", A_CTRL, 32'h80 | 32'(m << 3));
    end
    $display("test modes done");
  endtask

  task automatic test_unlock();
    rst(1'b1);
    bus(1'b1, A_CTRL, 32'hE0);
    bus(1'b1, A_CMD, 32'h20C5);
    bus(1'b1, A_CMD, 32'h28D9);
    bus(1'b1, A_CTRL, 32'hE6);
    rdchk("in window", A_CTRL, 32'hE6);
    rdchk("no event", A_STAT, 32'h0);
    repeat (130) @(posedge hclk);
    bus(1'b1, A_CTRL, 32'hE7);
    rdchk("after window", A_CTRL, 32'hE6);
    rdchk("late write", A_STAT, 32'h02);
    $display("test unlock done");
  endtask

  task automatic test_event();
    time t0;
    int  k;
    rst(1'b1);
    bus(1'b1, A_CTRL, 32'hC0);
    bus(1'b1, A_CTRL, 32'hC4);
    rdchk("refused", A_CTRL, 32'hC0);
    rdchk("illegal", A_STAT, 32'h02);
    `CHK("masked irq", 1'b0, irq)
    bus(1'b1, A_MASK, 32'h02);
    repeat (2) @(posedge hclk);
    `CHK("irq", 1'b1, irq)
    `CHK("held reset", 1'b0, wdog_reset)
    @(posedge hclk);
    vector_fetch <= 1'b1;
    @(posedge hclk);
    vector_fetch <= 1'b0;
    t0 = $time;
    bus(1'b1, A_STAT, 32'h02);
    repeat (2) @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
    k = 0;
    while (wdog_reset !== 1'b1 && k < 300) begin
      @(posedge hclk);
      #1;
      k++;
    end
    `CHK("reset delay", 128, int'(($time - t0) / 20))
    $display("test event done");
  endtask

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end

  initial begin
    {hresetn, por_n, hsel, hwrite, count_tick, vector_fetch} = 6'h0;
    {debug_mode, wait_mode, stop_mode} = 3'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    test_reset();
    test_gates();
    test_modes();
    test_unlock();
    test_event();
    give_verdict();
  end
endmodule // test_watchdog_control_config

// [dv/wcc_watchdog_properties.sv]
// concurrent checks on the ports of the watchdog control block
`timescale 1ns/100ps

module wcc_watchdog_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        vector_fetch,
  input wire logic        irq,
  input wire logic        wdog_reset
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_unmapped;
    hsel && htrans[1] && hready && !hwrite && (haddr[31:8] != 24'h0);
  endsequence
  sequence s_fetch;
    vector_fetch && irq && !wdog_reset;
  endsequence
  sequence s_late;
    !wdog_reset ##1 wdog_reset;
  endsequence

  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  property p_idle;
    !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0;
  endproperty
  property p_unmapped;
    s_rd_unmapped |=> hrdata == 32'h0;
  endproperty
  property p_byte;
    hrdata[31:8] == 24'h0;
  endproperty
  property p_sticky;
    wdog_reset |=> wdog_reset;
  endproperty
  property p_vec;
    s_fetch |-> ##128 s_late;
  endproperty
  property p_irq_first;
    $rose(irq) |-> !wdog_reset;
  endproperty

  a_okay: assert property (p_okay) else $error("bus response not okay");
  a_ready: assert property (p_ready) else $error("wait state inserted");
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_byte: assert property (p_byte) else $error("read data above bit 7");
  a_sticky: assert property (p_sticky) else $error("reset request dropped");
  a_vec: assert property (p_vec) else $error("reset not 128 clocks after fetch");
  a_irq_first: assert property (p_irq_first) else $error("irq after reset");
endmodule // wcc_watchdog_properties

bind wcc_watchdog wcc_watchdog_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .vector_fetch, .irq, .wdog_reset);
